// file: pkg/watch_pkg.sv
package watch_pkg;
  // Time base
  localparam int CLK_HZ = 20_000_000;
  localparam int BP_HZ = 32;
  localparam int HALF_BP_CYCLES = CLK_HZ / (2 * BP_HZ);
  localparam int FOUT_HI_HZ = 1024;
  localparam int FOUT_LO_HZ = 256;
  localparam int FOUT_HALF_HI_CYCLES = CLK_HZ / (2 * FOUT_HI_HZ);
  localparam int FOUT_HALF_LO_CYCLES = CLK_HZ / (2 * FOUT_LO_HZ);
  // Display timing, counted in 32 Hz ticks or seconds
  localparam int REVERT_MS = 2250;
  localparam logic [6:0] REVERT_TICKS = 7'(REVERT_MS * BP_HZ / 1000);
  localparam int ALT_SECONDS = 2;
  localparam logic [4:0] PH_LAST = 5'h1F;
  localparam logic [4:0] STEP_MASK_1HZ = 5'h1F;
  localparam logic [4:0] STEP_MASK_2HZ = 5'h0F;
  localparam logic [4:0] FAST_MASK_1HZ = 5'h07;
  localparam logic [4:0] FAST_MASK_2HZ = 5'h03;
  // Known state after reset or test entry
  localparam logic [3:0] START_HOUR = 4'h1;
  localparam logic [3:0] START_MONTH = 4'h1;
  localparam logic [4:0] START_DATE = 5'h01;
  // Register map, byte addresses
  localparam logic [3:0] TIME_OFS = 4'h0;
  localparam logic [3:0] DATE_OFS = 4'h4;
  localparam logic [3:0] STATUS_OFS = 4'h8;
  localparam logic [3:0] CTRL_OFS = 4'hC;
  localparam int CTRL_FAST_BIT = 0;
  localparam int CTRL_RATE2_BIT = 1;
  // Digit codes beyond 0..9
  localparam logic [3:0] DIG_A = 4'hA;
  localparam logic [3:0] DIG_P = 4'hB;
  localparam logic [3:0] DIG_BLANK = 4'hF;

  typedef enum logic [8:0] {
    ST_DISP1 = 9'h001,
    ST_D1_DATE = 9'h002,
    ST_D1_SEC = 9'h004,
    ST_DISP2 = 9'h008,
    ST_D2_SEC = 9'h010,
    ST_SET_MON = 9'h020,
    ST_SET_DATE = 9'h040,
    ST_SET_HOUR = 9'h080,
    ST_SET_MIN = 9'h100
  } state_t;
endpackage

// file: src/button_debounce.sv
`timescale 1ns/100ps
// Accepts a new level only after two agreeing samples at the debounce rate
module button_debounce (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic sample_i,
  input wire logic raw_i,
  output logic level_o,
  output logic press_o
);
  logic last;
  // Both closure and release must be stable across a sample interval
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      last <= 1'b0;
      level_o <= 1'b0;
    end else if (sample_i) begin
      last <= raw_i;
      if (last == raw_i) begin
        level_o <= raw_i;
      end
    end
  end
  assign press_o = sample_i && (last == raw_i) && raw_i && !level_o;
endmodule

// file: src/watch_ctrl.sv
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// - Cycle in hour-set enters minute-set, colon lit
// - Set while cycle held: hold, no step
// - Set after cycle released: hold, step minutes
// - Cycle in minute-set returns to first display
// - First display colon blinks, steady under hold
// - Alternating display shows colon steady on time
// - Set in either display clears hold
// - Step rate 1 or 2 Hz, fast four times
// - Stop forces segments off, halts time base
// - Buttons debounced both edges at 8/16 Hz
// - Segments drive 32 Hz, inverted when lit
// - Colon same drive, blinks or steady per mode
// - Monitor output gives 256 or 1024 Hz
// - Test high turns backplane pad into clock input
// - Test high drops phase control, zero reference
// - Test rising resets to 1 AM January first
// - Alternating cycle walks month, date, hour set
// - Alternating display swaps every two seconds
// - First display set shows date, reverts, seconds
// - Four-year calendar with leap February
module watch_ctrl #(
  parameter int HALF_BP = watch_pkg::HALF_BP_CYCLES,
  parameter int FOUT_HALF_HI = watch_pkg::FOUT_HALF_HI_CYCLES,
  parameter int FOUT_HALF_LO = watch_pkg::FOUT_HALF_LO_CYCLES,
  parameter bit FOUT_1024 = 1'b1,
  parameter bit DEBOUNCE_16HZ = 1'b0,
  parameter bit SET_RATE_2HZ = 1'b0,
  parameter bit FAST_SET = 1'b1
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic set_btn_i,
  input wire logic cycle_btn_i,
  input wire logic stop_i,
  input wire logic test_i,
  input wire logic backplane_pad_i,
  output logic backplane_pad_o,
  output logic backplane_pad_oe_o,
  output logic [27:0] seg_o,
  output logic colon_o,
  output logic fout_o
);
  watch_pkg::state_t state, next_state;
  logic [18:0] bp_cnt;
  logic [15:0] fout_cnt;
  logic int_bp, test_q, pad_q;
  logic [4:0] ph;
  logic [6:0] revert_cnt;
  logic [1:0] alt_cnt;
  logic hold, armed, fast, fast_en, rate2;
  logic [5:0] sec, minute;
  logic [3:0] hour, month;
  logic pm;
  logic [4:0] date;
  logic [1:0] year;

  // Time base: internal 32 Hz, or rising pad edges in test mode
  wire bp_end = (bp_cnt == 19'(HALF_BP - 1));
  wire int_tick = bp_end && int_bp && !stop_i;
  wire ext_tick = backplane_pad_i && !pad_q && !stop_i;
  wire tick32 = test_i ? ext_tick : int_tick;
  wire bp_level = test_i ? 1'b0 : int_bp;
  wire test_rise = test_i && !test_q;
  wire sec_tick = tick32 && (ph == watch_pkg::PH_LAST);
  wire sample = tick32 && (DEBOUNCE_16HZ ? ph[0] : (ph[1:0] == 2'h3));
  wire [4:0] step_mask = fast ?
    (rate2 ? watch_pkg::FAST_MASK_2HZ : watch_pkg::FAST_MASK_1HZ) :
    (rate2 ? watch_pkg::STEP_MASK_2HZ : watch_pkg::STEP_MASK_1HZ);
  wire step_tick = tick32 && ((ph & step_mask) == step_mask);

  // Stop halts the divider too, so nothing moves while stored
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || bp_end) begin
      bp_cnt <= 19'h00000;
    end else if (!stop_i) begin
      bp_cnt <= bp_cnt + 19'h00001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      int_bp <= 1'b0;
      test_q <= 1'b0;
      pad_q <= 1'b0;
      ph <= 5'h00;
    end else begin
      if (int_tick || (bp_end && !stop_i)) begin
        int_bp <= !int_bp;
      end
      test_q <= test_i;
      pad_q <= backplane_pad_i;
      if (tick32) begin
        ph <= ph + 5'h01;
      end
    end
  end

  // Oscillator monitor output
  wire [15:0] fout_half = FOUT_1024 ? 16'(FOUT_HALF_HI - 1) : 16'(FOUT_HALF_LO - 1);
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      fout_cnt <= 16'h0000;
      fout_o <= 1'b0;
    end else if (!stop_i) begin
      fout_cnt <= (fout_cnt == fout_half) ? 16'h0000 : fout_cnt + 16'h0001;
      if (fout_cnt == fout_half) begin
        fout_o <= !fout_o;
      end
    end
  end

  // Button conditioning
  logic set_lv, set_p, cyc_lv, cyc_p;
  button_debounce u_set_db (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .sample_i(sample),
    .raw_i(set_btn_i),
    .level_o(set_lv),
    .press_o(set_p)
  );
  button_debounce u_cyc_db (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .sample_i(sample),
    .raw_i(cycle_btn_i),
    .level_o(cyc_lv),
    .press_o(cyc_p)
  );

  // Mode sequencing; cycle with set held in a set mode is taken as fast-set, not advance
  wire in_set = state[5] | state[6] | state[7] | state[8];
  wire cyc_adv = cyc_p && !(in_set && set_lv && fast_en);
  wire reverted = (revert_cnt == watch_pkg::REVERT_TICKS);
  always_comb begin
    next_state = state;
    case (state)
      watch_pkg::ST_DISP1: begin
        if (set_p) next_state = watch_pkg::ST_D1_DATE;
        else if (cyc_p) next_state = watch_pkg::ST_DISP2;
      end
      watch_pkg::ST_D1_DATE: begin
        if (set_p) next_state = watch_pkg::ST_D1_SEC;
        else if (reverted) next_state = watch_pkg::ST_DISP1;
      end
      watch_pkg::ST_D1_SEC: begin
        if (set_p) next_state = watch_pkg::ST_DISP1;
      end
      watch_pkg::ST_DISP2: begin
        if (set_p) next_state = watch_pkg::ST_D2_SEC;
        else if (cyc_p) next_state = watch_pkg::ST_SET_MON;
      end
      watch_pkg::ST_D2_SEC: begin
        if (set_p) next_state = watch_pkg::ST_DISP2;
      end
      watch_pkg::ST_SET_MON: begin
        if (cyc_adv) next_state = watch_pkg::ST_SET_DATE;
      end
      watch_pkg::ST_SET_DATE: begin
        if (cyc_adv) next_state = watch_pkg::ST_SET_HOUR;
      end
      watch_pkg::ST_SET_HOUR: begin
        if (cyc_adv) next_state = watch_pkg::ST_SET_MIN;
      end
      watch_pkg::ST_SET_MIN: begin
        if (cyc_adv) next_state = watch_pkg::ST_DISP1;
      end
      default: next_state = watch_pkg::ST_DISP1;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || test_rise) begin
      state <= watch_pkg::ST_DISP1;
    end else begin
      state <= next_state;
    end
  end

  // Hold, step arming and fast-set flags
  wire set_in_min = state[8] && set_p;
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || test_rise) begin
      hold <= 1'b0;
      armed <= 1'b0;
      fast <= 1'b0;
    end else begin
      if (set_in_min) begin
        hold <= 1'b1;
      end else if (set_p && (state[0] || state[3])) begin
        hold <= 1'b0;
      end
      if (set_in_min) begin
        armed <= !cyc_lv;
      end else if (!set_lv) begin
        armed <= 1'b0;
      end
      if (!set_lv) begin
        fast <= 1'b0;
      end else if (in_set && cyc_p && fast_en) begin
        fast <= 1'b1;
      end
    end
  end

  // Revert timer counts only after set is released
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || !state[1] || set_lv) begin
      revert_cnt <= 7'h00;
    end else if (tick32 && !reverted) begin
      revert_cnt <= revert_cnt + 7'h01;
    end
  end

  // Alternating display phase, two seconds per half
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || !state[3]) begin
      alt_cnt <= 2'h0;
    end else if (sec_tick) begin
      alt_cnt <= alt_cnt + 2'h1;
    end
  end
  wire alt_date = alt_cnt[1];

  // Calendar carry chain
  function automatic logic [4:0] month_days(input logic [3:0] m, input logic [1:0] y);
    case (m)
      4'h2: month_days = (y == 2'h0) ? 5'd29 : 5'd28;
      4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'd30;
      default: month_days = 5'd31;
    endcase
  endfunction

  wire sec_wrap = (sec == 6'd59);
  wire min_wrap = (minute == 6'd59);
  wire day_end = (hour == 4'd11) && pm;
  wire date_wrap = (date == month_days(month, year));
  wire mon_wrap = (month == 4'd12);
  wire [5:0] min_inc = min_wrap ? 6'd0 : minute + 6'd1;
  wire [3:0] hour_inc = (hour == 4'd12) ? 4'd1 : hour + 4'd1;
  wire pm_inc = (hour == 4'd11) ? !pm : pm;
  wire [4:0] date_inc = date_wrap ? 5'd1 : date + 5'd1;
  wire [3:0] mon_inc = mon_wrap ? 4'd1 : month + 4'd1;
  wire set_step = step_tick && set_lv;
  wire run_sec = sec_tick && !hold;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || test_rise) begin
      sec <= 6'd0;
      minute <= 6'd0;
      hour <= watch_pkg::START_HOUR;
      pm <= 1'b0;
      date <= watch_pkg::START_DATE;
      month <= watch_pkg::START_MONTH;
      year <= 2'h0;
    end else if (set_step && in_set) begin
      if (state[5]) month <= mon_inc;
      if (state[6]) date <= date_inc;
      if (state[7]) begin
        hour <= hour_inc;
        pm <= pm_inc;
      end
      if (state[8] && armed) minute <= min_inc;
    end else if (run_sec) begin
      sec <= sec_wrap ? 6'd0 : sec + 6'd1;
      if (sec_wrap) minute <= min_inc;
      if (sec_wrap && min_wrap) begin
        hour <= hour_inc;
        pm <= pm_inc;
      end
      if (sec_wrap && min_wrap && day_end) begin
        date <= date_inc;
        if (date_wrap) month <= mon_inc;
        if (date_wrap && mon_wrap) year <= year + 2'h1;
      end
    end
  end

  // Display content selection
  function automatic logic [7:0] two_dig(input logic [5:0] v, input logic blank_zero);
    logic [3:0] t;
    t = 4'(v / 6'd10);
    two_dig = {(blank_zero && t == 4'h0) ? watch_pkg::DIG_BLANK : t, 4'(v % 6'd10)};
  endfunction

  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: seg7 = 7'h3F;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5B;
      4'h3: seg7 = 7'h4F;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6D;
      4'h6: seg7 = 7'h7D;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7F;
      4'h9: seg7 = 7'h6F;
      4'hA: seg7 = 7'h77;
      4'hB: seg7 = 7'h73;
      default: seg7 = 7'h00;
    endcase
  endfunction

  wire show_time = (state[0] || (state[3] && !alt_date));
  wire show_date = state[1] || (state[3] && alt_date);
  wire show_sec = state[2] || state[4];
  wire [7:0] blank2 = {watch_pkg::DIG_BLANK, watch_pkg::DIG_BLANK};
  wire [7:0] hour_d = two_dig({2'h0, hour}, 1'b1);
  wire [7:0] mon_d = two_dig({2'h0, month}, 1'b1);
  wire [7:0] date_d = two_dig({1'b0, date}, 1'b1);
  wire [7:0] min_d = two_dig(minute, 1'b0);
  wire [7:0] sec_d = two_dig(sec, 1'b0);
  wire [7:0] ampm_d = {watch_pkg::DIG_BLANK, pm ? watch_pkg::DIG_P : watch_pkg::DIG_A};
  wire [7:0] left_d = (show_time || state[7]) ? hour_d :
                      (show_date || state[5]) ? mon_d : blank2;
  wire [7:0] right_d = (show_time || state[8]) ? min_d :
                       (show_date || state[6]) ? date_d :
                       show_sec ? sec_d :
                       state[7] ? ampm_d : blank2;
  wire [27:0] lit = stop_i ? 28'h0000000 :
    {seg7(left_d[7:4]), seg7(left_d[3:0]), seg7(right_d[7:4]), seg7(right_d[3:0])};
  // Colon: blink from the 32 Hz phase, steady under hold or while setting hour or minute
  wire colon_lit = !stop_i && ((state[0] && (hold || ph[4])) ||
                               (state[3] && !alt_date) ||
                               state[7] || state[8]);

  // Phase-controlled drive; registered so the pads never glitch
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      seg_o <= 28'h0000000;
      colon_o <= 1'b0;
    end else begin
      seg_o <= lit ^ {28{bp_level}};
      colon_o <= colon_lit ^ bp_level;
    end
  end
  assign backplane_pad_o = int_bp;
  assign backplane_pad_oe_o = !test_i;

  // Wishbone slave: one wait state, unmapped reads return zero
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire ctrl_wr = wb_req && wb_we_i && (wb_adr_i == watch_pkg::CTRL_OFS) && wb_sel_i[0];
  wire [31:0] time_word = {9'h000, pm, 2'h0, hour, 2'h0, minute, 2'h0, sec};
  wire [31:0] date_word = {16'h0000, 2'h0, year, month, 3'h0, date};
  wire [31:0] status_word = {21'h000000, fast, hold, state};
  wire [31:0] ctrl_word = {30'h00000000, rate2, fast_en};
  wire [31:0] rd_word =
    (wb_adr_i == watch_pkg::TIME_OFS) ? time_word :
    (wb_adr_i == watch_pkg::DATE_OFS) ? date_word :
    (wb_adr_i == watch_pkg::STATUS_OFS) ? status_word :
    (wb_adr_i == watch_pkg::CTRL_OFS) ? ctrl_word : 32'h00000000;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      fast_en <= FAST_SET;
      rate2 <= SET_RATE_2HZ;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_word : 32'h00000000;
      if (ctrl_wr) begin
        fast_en <= wb_dat_i[watch_pkg::CTRL_FAST_BIT];
        rate2 <= wb_dat_i[watch_pkg::CTRL_RATE2_BIT];
      end
    end
  end
endmodule

// file: testbench/watch_ctrl_sva.sv
`timescale 1ns/100ps
// Port-level checks of the watch control block
module watch_ctrl_sva #(
  parameter int HALF_BP = 4,
  parameter int FOUT_HALF_HI = 3
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic stop_i,
  input wire logic test_i,
  input wire logic backplane_pad_o,
  input wire logic backplane_pad_oe_o,
  input wire logic [27:0] seg_o,
  input wire logic colon_o,
  input wire logic fout_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic bp_q, bp_ok, fo_q, fo_ok;
  int bp_n, fo_n, stop_n;
  wire bp_chg = bp_q != backplane_pad_o;
  wire fo_chg = fo_q != fout_o;
  // Cycles since the last edge; stop spoils both counts, test the backplane count, so they restart
  always_ff @(posedge clk_sys_i) begin
    bp_q <= backplane_pad_o;
    fo_q <= fout_o;
    bp_n <= (bp_chg || stop_i || test_i) ? 0 : bp_n + 1;
    fo_n <= (fo_chg || stop_i) ? 0 : fo_n + 1;
    bp_ok <= reset_n_i && !stop_i && !test_i && (bp_ok || bp_chg);
    fo_ok <= reset_n_i && !stop_i && (fo_ok || fo_chg);
    stop_n <= (stop_i && !test_i) ? stop_n + 1 : 0;
  end

  a_pad_dir_test:
    assert property (backplane_pad_oe_o == !test_i) else $error("pad direction wrong");
  a_stop_segs_off:
    assert property (stop_n >= 3 && !bp_chg |-> seg_o == {28{backplane_pad_o}})
    else $error("segments lit under stop");
  a_stop_colon_off:
    assert property (stop_n >= 3 && !bp_chg |-> colon_o == backplane_pad_o)
    else $error("colon lit under stop");
  a_bp_half_period:
    assert property (bp_chg && bp_ok |-> bp_n == HALF_BP - 1) else $error("backplane period");
  a_fout_half_period:
    assert property (fo_chg && fo_ok |-> fo_n == FOUT_HALF_HI - 1) else $error("monitor period");
  a_ack_one_cycle:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_next_cycle:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_rdata_idle_zero:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  cover property (stop_n == 5);
  cover property ($rose(test_i));
  cover property (wb_ack_o && wb_cyc_i);
endmodule

bind watch_ctrl watch_ctrl_sva #(.HALF_BP(HALF_BP), .FOUT_HALF_HI(FOUT_HALF_HI)) sva (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_i(stop_i), .test_i(test_i),
  .backplane_pad_o(backplane_pad_o), .backplane_pad_oe_o(backplane_pad_oe_o),
  .seg_o(seg_o), .colon_o(colon_o), .fout_o(fout_o));

// file: testbench/watch_front.sv
`timescale 1ns/100ps
// Two bouncing push-buttons and a panel that reads segments mid-phase
module watch_front (
  input wire logic clk_sys_i,
  input wire logic set_hold_i,
  input wire logic cycle_hold_i,
  input wire logic [27:0] seg_i,
  input wire logic colon_i,
  input wire logic bp_i,
  output logic set_btn_o,
  output logic cycle_btn_o,
  output logic [27:0] lit_o,
  output logic colon_lit_o
);
  logic [2:0] s_chat = 3'h0;
  logic [2:0] c_chat = 3'h0;
  logic [2:0] age = 3'h0;
  logic s_q = 1'b0;
  logic c_q = 1'b0;
  logic bp_q = 1'b0;
  // Chatter of five clocks, far shorter than one debounce sample
  assign set_btn_o = set_hold_i ^ s_chat[0];
  assign cycle_btn_o = cycle_hold_i ^ c_chat[0];
  // Panel settles two clocks after a backplane edge, like a slow LCD;
  // skips the clock where the registered drive still lags the edge
  always_ff @(posedge clk_sys_i) begin
    s_q <= set_hold_i;
    c_q <= cycle_hold_i;
    s_chat <= (s_q != set_hold_i) ? 3'h5 : ((s_chat != 3'h0) ? s_chat - 3'h1 : 3'h0);
    c_chat <= (c_q != cycle_hold_i) ? 3'h5 : ((c_chat != 3'h0) ? c_chat - 3'h1 : 3'h0);
    bp_q <= bp_i;
    age <= (bp_q != bp_i) ? 3'h0 : age + {2'h0, age != 3'h7};
    if (age >= 3'h2 && bp_q == bp_i) begin
      lit_o <= seg_i ^ {28{bp_i}};
      colon_lit_o <= colon_i ^ bp_i;
    end
  end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the watch control block
module tb_top;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic set_hold = 1'b0;
  logic cyc_hold = 1'b0;
  logic stop = 1'b0;
  logic test = 1'b0;
  logic pad_drv = 1'b0;
  logic [31:0] rd, t0, wb_dat_o;
  logic wb_ack_o, bp_o, bp_oe, colon_o, fout_o, set_btn, cyc_btn, colon_lit;
  logic [27:0] seg_o, lit;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int on;
  // The pad wire: our driver only when the block has let go
  wire pad = bp_oe ? bp_o : pad_drv;

  initial forever #25 clk_sys_i = ~clk_sys_i;

  watch_ctrl #(.HALF_BP(4), .FOUT_HALF_HI(3), .FOUT_HALF_LO(3)) dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .set_btn_i(set_btn), .cycle_btn_i(cyc_btn), .stop_i(stop),
    .test_i(test), .backplane_pad_i(pad), .backplane_pad_o(bp_o),
    .backplane_pad_oe_o(bp_oe), .seg_o(seg_o), .colon_o(colon_o), .fout_o(fout_o));

  watch_front front (
    .clk_sys_i(clk_sys_i), .set_hold_i(set_hold), .cycle_hold_i(cyc_hold), .seg_i(seg_o),
    .colon_i(colon_o), .bp_i(pad), .set_btn_o(set_btn), .cycle_btn_o(cyc_btn),
    .lit_o(lit), .colon_lit_o(colon_lit));

  task automatic stop_test();
    if (fails == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, well above the longest expected run
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("Error %0t %s", $time, msg);
    end
  endtask

  task automatic clks(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic st(input logic [31:0] e);
    bus(1'b0, watch_pkg::STATUS_OFS, 32'h0);
    chk(rd === e, "wrong state");
  endtask

  // Long enough for two agreeing 8 Hz samples
  task automatic btn(input logic s, input logic c);
    set_hold <= s;
    cyc_hold <= c;
    clks(120);
  endtask

  task automatic colon_count();
    on = 0;
    repeat (300) begin
      @(posedge clk_sys_i);
      on += (colon_lit === 1'b1);
    end
  endtask

  task automatic t_regs();
    st(32'h1);
    bus(1'b0, watch_pkg::DATE_OFS, 32'h0);
    chk(rd === 32'h101, "reset date");
    bus(1'b1, watch_pkg::CTRL_OFS, 32'h0);
    bus(1'b0, watch_pkg::CTRL_OFS, 32'h0);
    chk(rd === 32'h0, "control write");
    bus(1'b1, watch_pkg::CTRL_OFS, 32'h1);
    bus(1'b1, 4'h2, 32'hFFFFFFFF);
    bus(1'b0, 4'h2, 32'h0);
    chk(rd === 32'h0, "unmapped read");
  endtask

  task automatic t_walk();
    logic [31:0] exp [5] = '{32'h8, 32'h20, 32'h40, 32'h80, 32'h100};
    for (int i = 0; i < 5; i++) begin
      btn(1'b0, 1'b1);
      st(exp[i]);
      if (i < 4)
        btn(1'b0, 1'b0);
    end
  endtask

  task automatic t_hold();
    btn(1'b1, 1'b1);
    st(32'h300);
    bus(1'b0, watch_pkg::TIME_OFS, 32'h0);
    t0 = rd;
    btn(1'b0, 1'b1);
    btn(1'b0, 1'b0);
    bus(1'b0, watch_pkg::TIME_OFS, 32'h0);
    chk(rd === t0, "time moved");
    btn(1'b1, 1'b0);
    clks(800);
    btn(1'b0, 1'b0);
    bus(1'b0, watch_pkg::TIME_OFS, 32'h0);
    chk(rd[5:0] === t0[5:0], "seconds ran");
    chk((rd[13:8] - t0[13:8]) inside {6'h3, 6'h4}, "minute steps");
    // Set first, then cycle: fast-set, no mode advance
    btn(1'b1, 1'b0);
    btn(1'b1, 1'b1);
    st(32'h700);
    btn(1'b0, 1'b0);
    st(32'h300);
  endtask

  task automatic t_exit();
    btn(1'b0, 1'b1);
    st(32'h201);
    btn(1'b0, 1'b0);
    colon_count();
    chk(on == 300, "colon not steady");
    btn(1'b1, 1'b0);
    st(32'h2);
    btn(1'b0, 1'b0);
    clks(600);
    st(32'h1);
    colon_count();
    chk(on > 0 && on < 300, "colon not blinking");
  endtask

  task automatic t_stop();
    stop <= 1'b1;
    clks(20);
    chk(lit === 28'h0 && colon_lit === 1'b0, "display not blank");
    bus(1'b0, watch_pkg::TIME_OFS, 32'h0);
    t0 = rd;
    clks(300);
    bus(1'b0, watch_pkg::TIME_OFS, 32'h0);
    chk(rd === t0, "time ran");
    stop <= 1'b0;
  endtask

  task automatic t_test();
    logic [27:0] s0;
    test <= 1'b1;
    clks(4);
    chk(bp_oe === 1'b0, "pad still driven");
    st(32'h1);
    bus(1'b0, watch_pkg::TIME_OFS, 32'h0);
    chk(rd === 32'h10000, "test reset time");
    repeat (32) begin
      pad_drv <= 1'b1;
      clks(2);
      pad_drv <= 1'b0;
      clks(2);
    end
    bus(1'b0, watch_pkg::TIME_OFS, 32'h0);
    chk(rd[5:0] === 6'h1, "external ticks");
    s0 = seg_o;
    pad_drv <= 1'b1;
    clks(3);
    chk(seg_o === s0 && s0 !== 28'h0, "segments follow pad");
    test <= 1'b0;
    clks(4);
  endtask

  initial begin
    clks(8);
    reset_n_i <= 1'b1;
    t_regs();
    t_walk();
    t_hold();
    t_exit();
    t_stop();
    t_test();
    stop_test();
  end
endmodule
